// ==== frbg_rate_generator.v ====
`timescale 1ns/100ps
`include "frbg_map.vh"
module frbg_rate_generator (
   clk,
   rst_n,
   wr_en,
   wr_sel,
   wr_data,
   divisor_low_byte,
   divisor_high_byte,
   divisor_fraction_and_sampling,
   modem_control_register,
   sample_en,
   bit_en
);
   input wire clk;
   input wire rst_n;
   input wire wr_en;
   // 0 low, 1 high, 2 fraction, 3 modem control
   input wire [1:0] wr_sel;
   input wire [7:0] wr_data;
   output wire [7:0] divisor_low_byte;
   output wire [7:0] divisor_high_byte;
   output wire [7:0] divisor_fraction_and_sampling;
   output wire [7:0] modem_control_register;
   output reg sample_en;
   output reg bit_en;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] low_reg;
   reg [7:0] high_reg;
   reg [7:0] frac_reg;
   reg [7:0] mcr_reg;

   // host writes; reset gives divisor of one
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_reg <= `FRBG_DIV_LOW_RST;
         high_reg <= `FRBG_DIV_HIGH_RST;
         frac_reg <= `FRBG_FRAC_SAMP_RST;
         mcr_reg <= `FRBG_MODEM_CTRL_RST;
      end else if (wr_en) begin
         case (wr_sel)
            2'h0: low_reg <= wr_data;
            2'h1: high_reg <= wr_data;
            2'h2: frac_reg <= wr_data;
            default: mcr_reg <= wr_data;
         endcase
      end
   end

   assign divisor_low_byte = low_reg;
   assign divisor_high_byte = high_reg;
   assign divisor_fraction_and_sampling = frac_reg;
   assign modem_control_register = mcr_reg;

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   wire pre_en;
   frbg_prescaler u_pre (
      .clk(clk),
      .rst_n(rst_n),
      .div4_sel(mcr_reg[`FRBG_PRESCALE_BIT]),
      .pre_en(pre_en)
   );

   // ----------------------------------------
   // fractional divider
   // ----------------------------------------
   wire [15:0] int_div = {high_reg, low_reg};
   wire [3:0] frac = frac_reg[`FRBG_FRAC_MSB:`FRBG_FRAC_LSB];
   wire [1:0] samp = frac_reg[`FRBG_SAMP_MSB:`FRBG_SAMP_LSB];
   // zero integer acts as one so the divider never stalls
   wire [16:0] int_eff = (int_div == 16'h0000) ? 17'h00001 : {1'b0, int_div};
   reg [16:0] cnt_reg;
   reg [3:0] acc_reg;
   reg [3:0] samp_cnt_reg;
   reg extra;
   reg [4:0] acc_sum;
   reg [16:0] period;

   // accumulator adds frac each period; carry stretches one period by a
   // prescaled clock, so sixteen periods average int + frac/16
   always @* begin
      acc_sum = {1'b0, acc_reg} + {1'b0, frac};
      extra = acc_sum[4];
      period = int_eff + {16'h0000, extra};
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 17'h00001;
         acc_reg <= 4'h0;
         sample_en <= 1'b0;
      end else begin
         sample_en <= 1'b0;
         if (pre_en) begin
            if (cnt_reg >= period) begin
               cnt_reg <= 17'h00001;
               acc_reg <= acc_sum[3:0];
               sample_en <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 17'h00001;
            end
         end
      end
   end

   // ----------------------------------------
   // bit time: 16, 8 or 4 sampling periods
   // ----------------------------------------
   reg [3:0] last_cnt;
   always @* begin
      case (samp)
         `FRBG_SAMP_8X: last_cnt = 4'h7;
         `FRBG_SAMP_4X: last_cnt = 4'h3;
         default: last_cnt = 4'hF;
      endcase
   end

   // fractions not a multiple of 2 in 8X or of 4 in 4X leave bit lengths uneven: accepted jitter
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_cnt_reg <= 4'h0;
         bit_en <= 1'b0;
      end else begin
         bit_en <= 1'b0;
         if (sample_en) begin
            if (samp_cnt_reg >= last_cnt) begin
               samp_cnt_reg <= 4'h0;
               bit_en <= 1'b1;
            end else begin
               samp_cnt_reg <= samp_cnt_reg + 4'h1;
            end
         end
      end
   end
endmodule // frbg_rate_generator

// ==== frbg_map.vh ====
`ifndef FRBG_MAP_VH
`define FRBG_MAP_VH
// ----------------------------------------
// register reset values
// ----------------------------------------
`define FRBG_DIV_LOW_RST 8'h01
`define FRBG_DIV_HIGH_RST 8'h00
`define FRBG_FRAC_SAMP_RST 8'h00
`define FRBG_MODEM_CTRL_RST 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define FRBG_PRESCALE_BIT 7
`define FRBG_FRAC_MSB 3
`define FRBG_FRAC_LSB 0
`define FRBG_SAMP_MSB 5
`define FRBG_SAMP_LSB 4
// ----------------------------------------
// sampling mode codes and ratios
// ----------------------------------------
`define FRBG_SAMP_16X 2'h0
`define FRBG_SAMP_8X 2'h1
`define FRBG_SAMP_4X 2'h2
`define FRBG_PRESCALE_RATIO 2'h3
`define FRBG_FRAC_STEPS 5'h10
`endif

// ==== frbg_prescaler.v ====
`timescale 1ns/100ps
// ----------------------------------------
// divide-by-1-or-4 prescaler, output is an enable pulse
// ----------------------------------------
module frbg_prescaler (
   clk,
   rst_n,
   div4_sel,
   pre_en
);
   input wire clk;
   input wire rst_n;
   input wire div4_sel;
   output wire pre_en;

   reg [1:0] cnt_reg;

   // free count; divide by 4 passes one clock in four
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 2'h0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end

   assign pre_en = div4_sel ? (cnt_reg == `FRBG_PRESCALE_RATIO) : 1'b1;
endmodule // frbg_prescaler

// ==== frbg_sva.sv ====
`timescale 1ns/100ps
module frbg_sva(input wire clk, rst_n, wr_en, sample_en, bit_en,
   input wire [1:0] wr_sel, input wire [7:0] wr_data, divisor_low_byte,
   divisor_high_byte, divisor_fraction_and_sampling, modem_control_register);
   wire [7:0] lo = divisor_low_byte, hi = divisor_high_byte;
   wire [7:0] fs = divisor_fraction_and_sampling, mc = modem_control_register;
   wire [16:0] d = {hi, lo} == 16'h0 ? 17'h1 : {1'b0, hi, lo};
   reg [16:0] cnt_reg;
   reg [1:0] seen_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // clocks since last tick; a write restarts the settle count, first period may be short
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 17'h1;
         seen_reg <= 2'h0;
      end else begin
         cnt_reg <= sample_en ? 17'h1 : cnt_reg + 17'h1;
         seen_reg <= wr_en ? 2'h0 : seen_reg + {1'b0, sample_en && seen_reg != 2'h2};
      end
   end
   property p_rst; $rose(rst_n) |-> lo == 8'h01 && hi == 8'h00 && fs == 8'h00; endproperty
   property p_wl; wr_en && wr_sel == 2'h0 |=> lo == $past(wr_data); endproperty
   property p_wh; wr_en && wr_sel == 2'h1 |=> hi == $past(wr_data); endproperty
   property p_wf; wr_en && wr_sel == 2'h2 |=> fs == $past(wr_data); endproperty
   property p_wm; wr_en && wr_sel == 2'h3 |=> mc == $past(wr_data); endproperty
   property p_be; bit_en |-> $past(sample_en); endproperty
   property p_pre; mc[7] && $past(mc[7]) && sample_en |=> !sample_en [*3]; endproperty
   property p_int; sample_en && seen_reg == 2'h2 && fs[3:0] == 4'h0 && !mc[7] |-> cnt_reg == d;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_wl: assert property (p_wl) else $error("low byte write");
   a_wh: assert property (p_wh) else $error("high byte write");
   a_wf: assert property (p_wf) else $error("fraction write");
   a_wm: assert property (p_wm) else $error("modem control write");
   a_be: assert property (p_be) else $error("bit pulse without tick");
   a_pre: assert property (p_pre) else $error("prescale too fast");
   a_int: assert property (p_int) else $error("integer period");
   c_bit: cover property (bit_en);
   c_pre: cover property (sample_en && mc[7]);
   c_mode: cover property (wr_en && wr_sel == 2'h2);
endmodule // frbg_sva
bind frbg_rate_generator frbg_sva u_sva(.*);

// ==== frbg_uart_model.sv ====
`timescale 1ns/100ps
module frbg_uart_model(input wire clk, rst_n, sample_en, bit_en, output int spb);
   int n;
   // ticks per bit time as the shifters see them; a tick with bit_en opens the next bit
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         n <= 0;
         spb <= 0;
      end else if (bit_en) begin
         spb <= n;
         n <= sample_en;
      end else n <= n + sample_en;
   end
endmodule // frbg_uart_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   reg clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0;
   reg [1:0] wr_sel = 2'h0;
   reg [7:0] wr_data = 8'h00;
   wire [7:0] lo, hi, fs, mc;
   wire se, be;
   int spb, num_errors = 0, checks_done = 0, seed = 67326, i, d, f, m, p, n, k;
   frbg_rate_generator dut(.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_sel(wr_sel),
      .wr_data(wr_data), .divisor_low_byte(lo), .divisor_high_byte(hi),
      .divisor_fraction_and_sampling(fs), .modem_control_register(mc), .sample_en(se),
      .bit_en(be));
   frbg_uart_model far(.clk(clk), .rst_n(rst_n), .sample_en(se), .bit_en(be), .spb(spb));
   initial forever #2.5 clk = ~clk;
   task finish_test;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input string s, input int e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %0d got %0d", s, e, g);
      end
   endtask
   task wr(input int s, input int v);
      @(negedge clk) wr_en = 1'b1;
      wr_sel = s[1:0];
      wr_data = v[7:0];
      @(negedge clk) wr_en = 1'b0;
   endtask
   // bounded wait for the next tick, n counts clocks
   task tick;
      k = 0;
      do begin
         @(negedge clk);
         n++;
         k++;
      end while (se !== 1'b1 && k < 5000);
      if (k >= 5000) begin
         num_errors++;
         finish_test;
      end
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      chk("low", 1, lo);
      chk("high", 0, hi);
      chk("frac", 0, fs);
      for (i = 0; i < 8; i++) begin
         d = 1 + {$random(seed)} % 6;
         f = i ? {$random(seed)} % 16 : 0;
         m = i % 4;
         p = i / 4;
         // divisor is programmed before each measurement, randomly from 1 to 6
         wr(3, p << 7);
         wr(2, m << 4 | f);
         wr(1, d >> 8);
         wr(0, d & 255);
         chk("mcr", p << 7, mc);
         chk("frac", m << 4 | f, fs);
         chk("div", d, {hi, lo});
         repeat (40) tick;
         n = 0;
         repeat (16) tick;
         chk("period16", (p ? 4 : 1) * (16 * d + f), n);
         chk("spb", m == 3 ? 16 : 16 >> m, spb);
         $display("test %0d done", i);
      end
      // mid-run reset must restore the divisor of one
      @(negedge clk) rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk("low", 1, lo);
      chk("high", 0, hi);
      chk("frac", 0, fs);
      chk("mcr", 0, mc);
      $display("test reset done");
      finish_test;
   end
endmodule // tb_top
